// [datapath_pkg.sv]
package datapath_pkg;

   // data and address widths
   localparam int DATA_W = 8;
   localparam int ADDR_W = 12;
   localparam int BANK_W = 4;
   localparam int BUS_ADDR_W = 8;
   localparam int BUS_DATA_W = 32;

   // instruction timing, in quarters and instruction cycles
   localparam int QUARTERS_PER_CYCLE = 4;
   localparam logic [1:0] Q_DECODE = 2'h0;
   localparam logic [1:0] Q_READ = 2'h1;
   localparam logic [1:0] Q_PROCESS = 2'h2;
   localparam logic [1:0] Q_WRITE = 2'h3;
   localparam logic [1:0] SKIP_CYCLES_ONE_WORD = 2'h1;
   localparam logic [1:0] SKIP_CYCLES_TWO_WORD = 2'h2;

   // instruction encodings
   localparam logic [15:0] OPC_DECIMAL_ADJUST = 16'h0007;
   localparam logic [6:0] OPC_COMPARE_LESS = 7'h30;
   localparam logic [5:0] OPC_DECREMENT = 6'h01;
   localparam int OPC_DEST_BIT = 9;
   localparam int OPC_BANK_BIT = 8;

   // bcd and addressing constants
   localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
   localparam logic [3:0] BCD_CORRECTION = 4'h6;
   localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

   // register offsets (byte addresses)
   localparam logic [7:0] REG_ACCUM = 8'h00;
   localparam logic [7:0] REG_FLAGS = 8'h04;
   localparam logic [7:0] REG_BANK = 8'h08;
   localparam logic [7:0] REG_CONTROL = 8'h0C;
   localparam logic [7:0] REG_INDEX_BASE = 8'h10;
   localparam logic [7:0] REG_STATE = 8'h14;

   // field positions
   localparam int FLAG_CARRY = 0;
   localparam int FLAG_HALF = 1;
   localparam int FLAG_ZERO = 2;
   localparam int FLAG_NEG = 4;
   localparam int CTRL_EXTENDED = 0;

   // reset values
   localparam logic [7:0] RST_ACCUM = 8'h00;
   localparam logic [4:0] RST_FLAGS = 5'h00;
   localparam logic [3:0] RST_BANK = 4'h0;
   localparam logic RST_EXTENDED = 1'b0;
   localparam logic [11:0] RST_INDEX_BASE = 12'h000;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_EXEC = 2'b01,
      ST_SKIP = 2'b10
   } exec_state_t;

   typedef struct packed
   {
      logic [15:0] opcode;
      logic        next_two_word;
   } instr_t;

   typedef struct packed
   {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              re;
      logic              we;
   } file_req_t;

endpackage

// [bcd_adjust_unit.sv]
`timescale 1ns/1ps
`default_nettype none
module bcd_adjust_unit
   import datapath_pkg::*;
(
   // operand and flags
   input  wire logic [7:0] i_accum,
   input  wire logic       i_half_carry,
   input  wire logic       i_carry,
   // adjusted result
   output logic      [7:0] o_result,
   output logic            o_carry
);

   logic       low_fix;
   logic [4:0] low_sum;
   logic       high_carry_in;
   logic [4:0] high_in;
   logic       high_fix;
   logic [5:0] high_sum;

   always_comb
   begin
      low_fix = (i_accum[3:0] > BCD_DIGIT_MAX) | i_half_carry;
      low_sum = {1'b0, i_accum[3:0]}
              + (low_fix ? {1'b0, BCD_CORRECTION} : 5'h00);
      high_carry_in = i_half_carry | low_sum[4];
      high_in = {1'b0, i_accum[7:4]} + {4'h0, high_carry_in};
      high_fix = (high_in > {1'b0, BCD_DIGIT_MAX}) | i_carry;
      high_sum = {1'b0, high_in}
               + (high_fix ? {2'b00, BCD_CORRECTION} : 6'h00);
      o_result = {high_sum[3:0], low_sum[3:0]};
      o_carry = i_carry | (high_sum > 6'h0F);
   end

endmodule
`default_nettype wire

// [file_address_unit.sv]
`timescale 1ns/1ps
`default_nettype none
module file_address_unit
   import datapath_pkg::*;
(
   // instruction fields
   input  wire logic [7:0]        i_file,
   input  wire logic              i_bank_access,
   // addressing state
   input  wire logic              i_extended,
   input  wire logic [BANK_W-1:0] i_bank,
   input  wire logic [ADDR_W-1:0] i_index_base,
   // resolved address
   output logic      [ADDR_W-1:0] o_addr,
   output logic                   o_indexed
);

   always_comb
   begin
      o_indexed = 1'b0;
      if (i_bank_access)
      begin
         o_addr = {i_bank, i_file};
      end
      else if (i_extended && (i_file <= INDEXED_LIMIT))
      begin
         o_addr = i_index_base + {4'h0, i_file};
         o_indexed = 1'b1;
      end
      else if (i_file <= INDEXED_LIMIT)
      begin
         o_addr = {4'h0, i_file};
      end
      else
      begin
         o_addr = {ACCESS_HIGH_BANK, i_file};
      end
   end

endmodule
`default_nettype wire

// [bcd_adjust_decrement_compare_skip.sv]
// Behaviour
// - skip next when file below accumulator
// - one cycle, two on skip, three two-word
// - low nibble over nine or half-carry adds six
// - high nibble plus half-carry or low carry, corrected by six
// - decrement file register in four quarters
// - destination bit picks accumulator or file
// - bank bit picks access bank or bank select
// - extended set indexes low file addresses when bank bit clear
`timescale 1ns/1ps
`default_nettype none
module bcd_adjust_decrement_compare_skip
   import datapath_pkg::*;
#(
   parameter int QUARTER_DIV = 1
)
(
   // clock and reset
   input  wire logic                    i_clock,
   input  wire logic                    i_rst_n,
   // instruction from decoder
   input  wire logic                    i_instr_valid,
   input  wire datapath_pkg::instr_t    i_instr,
   output logic                         o_instr_ready,
   output logic                         o_done,
   output logic                         o_discard,
   output logic                         o_skip_active,
   // file register port
   output datapath_pkg::file_req_t      o_file,
   input  wire logic [7:0]              i_file_rdata,
   // register port
   input  wire logic [7:0]              i_reg_addr,
   input  wire logic [31:0]             i_reg_wdata,
   input  wire logic                    i_reg_we,
   input  wire logic                    i_reg_re,
   output logic      [31:0]             o_reg_rdata
);

   // elaboration check on the quarter divider
   if (QUARTER_DIV < 1 || QUARTER_DIV > 255)
   begin
      $error("QUARTER_DIV out of range");
   end

   localparam logic [7:0] DIV_LAST = 8'(QUARTER_DIV - 1);

   exec_state_t       state;
   logic [7:0]        div_cnt;
   logic              q_tick;
   logic [1:0]        quarter;
   logic [1:0]        skip_left;
   instr_t            cur;
   logic [7:0]        operand;
   logic [7:0]        result;
   logic              take_skip;
   logic              last_skip;
   logic [7:0]        accum;
   logic [4:0]        flags;
   logic [3:0]        bank;
   logic              extended;
   logic [11:0]       index_base;
   logic [11:0]       file_addr;
   logic              file_indexed;
   logic              last_indexed;
   logic [7:0]        bcd_result;
   logic              bcd_carry;
   logic              is_adjust;
   logic              is_compare;
   logic              is_decrement;
   logic              accept;
   logic              end_exec;
   logic              end_skip;

   // opcode class decode
   function automatic logic [2:0] classify(input logic [15:0] opc);
      classify = {opc == OPC_DECIMAL_ADJUST,
                  opc[15:9] == OPC_COMPARE_LESS,
                  opc[15:10] == OPC_DECREMENT};
   endfunction

   assign {is_adjust, is_compare, is_decrement} = classify(cur.opcode);
   assign o_instr_ready = (state == ST_IDLE);
   assign accept = i_instr_valid && o_instr_ready;
   assign q_tick = (state != ST_IDLE) && (div_cnt == DIV_LAST);
   assign end_exec = q_tick && (state == ST_EXEC) && (quarter == Q_WRITE);
   assign end_skip = q_tick && (state == ST_SKIP) && (quarter == Q_WRITE)
                     && (skip_left == 2'h1);
   assign o_skip_active = (state == ST_SKIP);

   bcd_adjust_unit u_bcd
   (
      .i_accum      (accum),
      .i_half_carry (flags[FLAG_HALF]),
      .i_carry      (flags[FLAG_CARRY]),
      .o_result     (bcd_result),
      .o_carry      (bcd_carry)
   );

   file_address_unit u_addr
   (
      .i_file        (i_instr.opcode[7:0]),
      .i_bank_access (i_instr.opcode[OPC_BANK_BIT]),
      .i_extended    (extended),
      .i_bank        (bank),
      .i_index_base  (index_base),
      .o_addr        (file_addr),
      .o_indexed     (file_indexed)
   );

   // quarter divider, restarted per instruction
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         div_cnt <= 8'h00;
      end
      else if (accept || q_tick)
      begin
         div_cnt <= 8'h00;
      end
      else if (state != ST_IDLE)
      begin
         div_cnt <= div_cnt + 8'h01;
      end
   end

   // sequencer: execute cycle then skip cycles
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state <= ST_IDLE;
         quarter <= Q_DECODE;
         skip_left <= 2'h0;
      end
      else if (accept)
      begin
         state <= ST_EXEC;
         quarter <= Q_DECODE;
      end
      else if (q_tick)
      begin
         quarter <= quarter + 2'h1;
         unique case (state)
            ST_EXEC:
            begin
               if (quarter == Q_WRITE)
               begin
                  if (take_skip)
                  begin
                     state <= ST_SKIP;
                     skip_left <= cur.next_two_word ? SKIP_CYCLES_TWO_WORD
                                                    : SKIP_CYCLES_ONE_WORD;
                  end
                  else
                  begin
                     state <= ST_IDLE;
                  end
               end
            end
            ST_SKIP:
            begin
               if (quarter == Q_WRITE)
               begin
                  skip_left <= skip_left - 2'h1;
                  if (skip_left == 2'h1)
                  begin
                     state <= ST_IDLE;
                  end
               end
            end
            default:
            begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // decode quarter: latch instruction and address
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cur <= '0;
         o_file.addr <= 12'h000;
         last_indexed <= 1'b0;
      end
      else if (accept)
      begin
         cur <= i_instr;
         o_file.addr <= file_addr;
         last_indexed <= file_indexed;
      end
   end

   // read in Q2, process in Q3
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_file.re <= 1'b0;
         operand <= 8'h00;
         result <= 8'h00;
         take_skip <= 1'b0;
      end
      else if (q_tick && state == ST_EXEC)
      begin
         o_file.re <= (quarter == Q_DECODE) && (is_compare || is_decrement);
         if (quarter == Q_DECODE)
         begin
            take_skip <= 1'b0;
         end
         if (quarter == Q_READ)
         begin
            operand <= i_file_rdata;
         end
         if (quarter == Q_PROCESS)
         begin
            take_skip <= is_compare && (operand < accum);
            result <= is_adjust ? bcd_result : operand - 8'h01;
         end
      end
   end

   // file write-back during Q4 when destination bit set
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_file.we <= 1'b0;
         o_file.wdata <= 8'h00;
      end
      else if (q_tick && state == ST_EXEC)
      begin
         o_file.we <= (quarter == Q_PROCESS) && is_decrement
                      && cur.opcode[OPC_DEST_BIT];
         if (quarter == Q_PROCESS)
         begin
            o_file.wdata <= operand - 8'h01;
         end
      end
   end

   // completion and discard pulses
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_done <= 1'b0;
         o_discard <= 1'b0;
         last_skip <= 1'b0;
      end
      else
      begin
         o_done <= (end_exec && !take_skip) || end_skip;
         o_discard <= end_exec && take_skip;
         if (end_exec)
         begin
            last_skip <= take_skip;
         end
      end
   end

   // accumulator: core write in Q4 wins over software
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         accum <= RST_ACCUM;
      end
      else if (end_exec && (is_adjust ||
               (is_decrement && !cur.opcode[OPC_DEST_BIT])))
      begin
         accum <= result;
      end
      else if (i_reg_we && i_reg_addr == REG_ACCUM)
      begin
         accum <= i_reg_wdata[7:0];
      end
   end

   // status flags
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         flags <= RST_FLAGS;
      end
      else if (end_exec && is_adjust)
      begin
         flags[FLAG_CARRY] <= bcd_carry;
      end
      else if (end_exec && is_decrement)
      begin
         flags[FLAG_ZERO] <= (result == 8'h00);
         flags[FLAG_NEG] <= result[7];
      end
      else if (i_reg_we && i_reg_addr == REG_FLAGS)
      begin
         flags <= i_reg_wdata[4:0];
      end
   end

   // addressing configuration
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         bank <= RST_BANK;
         extended <= RST_EXTENDED;
         index_base <= RST_INDEX_BASE;
      end
      else if (i_reg_we)
      begin
         if (i_reg_addr == REG_BANK)
         begin
            bank <= i_reg_wdata[3:0];
         end
         if (i_reg_addr == REG_CONTROL)
         begin
            extended <= i_reg_wdata[CTRL_EXTENDED];
         end
         if (i_reg_addr == REG_INDEX_BASE)
         begin
            index_base <= i_reg_wdata[11:0];
         end
      end
   end

   // read data, valid one cycle after the read strobe
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_reg_rdata <= 32'h0000_0000;
      end
      else if (i_reg_re)
      begin
         unique case (i_reg_addr)
            REG_ACCUM:      o_reg_rdata <= {24'h0, accum};
            REG_FLAGS:      o_reg_rdata <= {27'h0, flags};
            REG_BANK:       o_reg_rdata <= {28'h0, bank};
            REG_CONTROL:    o_reg_rdata <= {31'h0, extended};
            REG_INDEX_BASE: o_reg_rdata <= {20'h0, index_base};
            REG_STATE:      o_reg_rdata <= {24'h0, last_indexed, last_skip,
                                            skip_left, quarter, state};
            default:        o_reg_rdata <= 32'h0000_0000;
         endcase
      end
      else
      begin
         o_reg_rdata <= 32'h0000_0000;
      end
   end

endmodule
`default_nettype wire

// [bcd_adjust_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module bcd_adjust_sva
   import datapath_pkg::*;
(
   // clock and reset
   input wire logic                 i_clock,
   input wire logic                 i_rst_n,
   // instruction port
   input wire logic                 i_instr_valid,
   input wire datapath_pkg::instr_t i_instr,
   input wire logic                 o_instr_ready,
   input wire logic                 o_done,
   input wire logic                 o_discard,
   input wire logic                 o_skip_active,
   // file port
   input wire datapath_pkg::file_req_t o_file,
   input wire logic [7:0]           i_file_rdata
);
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_n);
   logic tk;
   logic dec;
   logic cmp;
   assign tk = i_instr_valid && o_instr_ready;
   assign dec = i_instr.opcode[15:10] == OPC_DECREMENT;
   assign cmp = i_instr.opcode[15:9] == OPC_COMPARE_LESS;
   take_hold_a: assert property (
      tk |=> !o_instr_ready) else $error("ready high after take");
   instr_timing_a: assert property (
      tk |=> (!o_done)[*4] ##1 (o_done ^ o_skip_active))
      else $error("instruction cycle length wrong");
   skip_len_a: assert property (
      $rose(o_skip_active) |-> o_skip_active[*4] ##1
      ((o_done && !o_skip_active) or (o_skip_active[*4] ##1 o_done)))
      else $error("skip length wrong");
   skip_discard_a: assert property (
      $rose(o_skip_active) |-> o_discard ##1 !o_discard)
      else $error("discard not a pulse at skip start");
   skip_busy_a: assert property (
      o_skip_active |-> !o_instr_ready) else $error("ready during skip");
   adjust_quiet_a: assert property (
      tk && i_instr.opcode == OPC_DECIMAL_ADJUST |=>
      (!o_file.re && !o_file.we)[*4] ##1 o_done)
      else $error("adjust touched file or took too long");
   read_quarter_a: assert property (
      tk && (dec || cmp) |-> ##2 o_file.re ##1 !o_file.re)
      else $error("operand read quarter wrong");
   dec_write_a: assert property (
      tk && dec && i_instr.opcode[OPC_DEST_BIT] |-> ##4 (o_file.we &&
      o_file.wdata == $past(i_file_rdata, 2) - 8'h01))
      else $error("decrement write back wrong");
   dec_accum_a: assert property (
      tk && dec && !i_instr.opcode[OPC_DEST_BIT] |=> (!o_file.we)[*5])
      else $error("file written for accumulator destination");
   high_addr_a: assert property (
      tk && (dec || cmp) && !i_instr.opcode[OPC_BANK_BIT] &&
      i_instr.opcode[7:0] > INDEXED_LIMIT |=>
      o_file.addr == {ACCESS_HIGH_BANK, $past(i_instr.opcode[7:0])})
      else $error("access bank high address wrong");
   cover property (tk && dec);
   cover property (tk && i_instr.opcode == OPC_DECIMAL_ADJUST);
   cover property (o_discard);
   cover property ($rose(o_skip_active) ##8 o_done);
endmodule
bind bcd_adjust_decrement_compare_skip bcd_adjust_sva chk (
   .i_clock(i_clock), .i_rst_n(i_rst_n), .i_instr_valid(i_instr_valid),
   .i_instr(i_instr), .o_instr_ready(o_instr_ready), .o_done(o_done),
   .o_discard(o_discard), .o_skip_active(o_skip_active),
   .o_file(o_file), .i_file_rdata(i_file_rdata));
`default_nettype wire

// [bcd_adjust_decrement_compare_skip_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module bcd_adjust_decrement_compare_skip_bench;
   import datapath_pkg::*;
   logic        i_clock = 1'b0;
   logic        i_rst_n = 1'b0;
   logic        i_instr_valid = 1'b0;
   instr_t      i_instr = '0;
   logic        o_instr_ready, o_done, o_discard, o_skip_active;
   file_req_t   o_file;
   wire logic [7:0] i_file_rdata;
   logic [7:0]  i_reg_addr = 8'h00;
   logic [31:0] i_reg_wdata = 32'h0;
   logic [31:0] o_reg_rdata;
   logic        i_reg_we = 1'b0;
   logic        i_reg_re = 1'b0;
   logic [7:0]  fval = 8'h00;
   logic [11:0] ra, wa;
   logic [7:0]  wd;
   int          wn, dn;
   int          fail_count = 0;
   int          check_count = 0;
   always #12.5 i_clock = ~i_clock;
   // released data line shows the inverse
   assign i_file_rdata = o_file.re ? fval : ~fval;
   always @(posedge i_clock)
   begin
      if (o_file.re)
         ra <= o_file.addr;
      if (o_file.we)
         {wa, wd} <= {o_file.addr, o_file.wdata};
      if (o_file.we)
         wn <= wn + 1;
      if (o_discard)
         dn <= dn + 1;
   end
   bcd_adjust_decrement_compare_skip #(.QUARTER_DIV(1)) dut (
      .i_clock(i_clock), .i_rst_n(i_rst_n), .i_instr_valid(i_instr_valid),
      .i_instr(i_instr), .o_instr_ready(o_instr_ready), .o_done(o_done),
      .o_discard(o_discard), .o_skip_active(o_skip_active),
      .o_file(o_file), .i_file_rdata(i_file_rdata),
      .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
      .i_reg_we(i_reg_we), .i_reg_re(i_reg_re), .o_reg_rdata(o_reg_rdata));
   task automatic finish_test();
      if (fail_count == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clock);
      i_reg_addr <= a;
      i_reg_wdata <= d;
      i_reg_we <= 1'b1;
      @(posedge i_clock);
      i_reg_we <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      @(posedge i_clock);
      i_reg_addr <= a;
      i_reg_re <= 1'b1;
      @(posedge i_clock);
      i_reg_re <= 1'b0;
      #1 chk(o_reg_rdata, e);
   endtask
   // cycles from take to done, counted after each edge
   task automatic exec(input logic [15:0] op, input logic tw, output int c);
      wn = 0;
      dn = 0;
      @(posedge i_clock);
      i_instr_valid <= 1'b1;
      i_instr <= {op, tw};
      @(posedge i_clock);
      i_instr_valid <= 1'b0;
      #1 c = 0;
      while (o_done !== 1'b1 && c < 20)
      begin
         @(posedge i_clock);
         #1 c++;
      end
      if (c == 20)
      begin
         fail_count++;
         $display("[ERR] %0t instruction timed out", $time);
         finish_test();
      end
   endtask
   function automatic logic [8:0] daw_exp(input logic [7:0] a,
                                          input logic h, input logic c);
      logic [4:0] lo, hi;
      lo = {1'b0, a[3:0]};
      if (lo > 5'h9 || h)
         lo = lo + 5'h6;
      hi = {1'b0, a[7:4]} + {4'h0, h | lo[4]};
      if (hi > 5'h9 || c)
         hi = hi + 5'h6;
      return {c | hi[4], hi[3:0], lo[3:0]};
   endfunction
   task automatic dcase(input logic [7:0] a, input logic h, input logic c);
      logic [8:0] e;
      int n;
      e = daw_exp(a, h, c);
      wr(REG_ACCUM, {24'h0, a});
      wr(REG_FLAGS, {27'h0, 3'h5, h, c});
      exec(OPC_DECIMAL_ADJUST, 1'b0, n);
      chk(32'(n), 32'h4);
      chk(32'(wn), 32'h0);
      rchk(REG_ACCUM, {24'h0, e[7:0]});
      rchk(REG_FLAGS, {27'h0, 3'h5, h, e[8]});
   endtask
   task automatic dec_case(input logic d, input logic a, input logic [7:0] f,
      input logic x, input logic [7:0] v, input logic [11:0] ea);
      logic [7:0] r;
      int n;
      r = v - 8'h01;
      wr(REG_CONTROL, {31'h0, x});
      wr(REG_ACCUM, 32'h5A);
      fval <= v;
      exec({OPC_DECREMENT, d, a, f}, 1'b0, n);
      chk(32'(n), 32'h4);
      chk({20'h0, ra}, {20'h0, ea});
      chk(32'(wn), {31'h0, d});
      if (d)
         chk({12'h0, wa, wd}, {12'h0, ea, r});
      rchk(REG_ACCUM, d ? 32'h5A : {24'h0, r});
      rchk(REG_STATE, {24'h0, x && !a && (f <= INDEXED_LIMIT), 7'h00});
   endtask
   task automatic cmp_case(input logic [7:0] v, input logic [7:0] w,
                           input logic tw, input int cy);
      int n;
      wr(REG_ACCUM, {24'h0, w});
      fval <= v;
      exec({OPC_COMPARE_LESS, 1'b1, 8'h20}, tw, n);
      chk(32'(n), 32'(cy));
      chk(32'(dn), {31'h0, cy > 4});
      chk(32'(wn), 32'h0);
      rchk(REG_ACCUM, {24'h0, w});
      rchk(REG_STATE, {24'h0, 1'b0, cy > 4, 6'h00});
   endtask
   initial
   begin
      int n;
      repeat (2) @(posedge i_clock);
      i_rst_n <= 1'b1;
      for (int i = 0; i < 6; i++)
         rchk(8'(4 * i), 32'h0);
      wr(8'h40, 32'hFFFFFFFF);
      rchk(8'h40, 32'h0);
      wr(REG_BANK, 32'h3);
      wr(REG_INDEX_BASE, 32'h200);
      dcase(8'hA5, 1'b0, 1'b0);
      dcase(8'hCE, 1'b0, 1'b0);
      dcase(8'h15, 1'b1, 1'b0);
      dcase(8'h42, 1'b0, 1'b1);
      dcase(8'h99, 1'b0, 1'b0);
      dcase(8'h9A, 1'b0, 1'b0);
      dcase(8'h0F, 1'b1, 1'b1);
      dec_case(1'b1, 1'b1, 8'h20, 1'b0, 8'h37, 12'h320);
      dec_case(1'b0, 1'b1, 8'h20, 1'b0, 8'h00, 12'h320);
      dec_case(1'b1, 1'b0, 8'h5F, 1'b0, 8'h01, 12'h05F);
      dec_case(1'b1, 1'b0, 8'h60, 1'b0, 8'h80, 12'hF60);
      dec_case(1'b0, 1'b0, 8'h5F, 1'b1, 8'h10, 12'h25F);
      dec_case(1'b1, 1'b0, 8'h60, 1'b1, 8'h44, 12'hF60);
      dec_case(1'b1, 1'b1, 8'h10, 1'b1, 8'h01, 12'h310);
      dec_case(1'b1, 1'b0, 8'h00, 1'b1, 8'h22, 12'h200);
      cmp_case(8'h7F, 8'h80, 1'b0, 8);
      cmp_case(8'h7F, 8'h80, 1'b1, 12);
      cmp_case(8'h80, 8'h7F, 1'b0, 4);
      cmp_case(8'h55, 8'h55, 1'b1, 4);
      cmp_case(8'h00, 8'h01, 1'b0, 8);
      cmp_case(8'hFE, 8'hFF, 1'b1, 12);
      cmp_case(8'h01, 8'h00, 1'b0, 4);
      wr(REG_ACCUM, 32'h5A);
      exec(16'hFFFF, 1'b0, n);
      chk(32'(n), 32'h4);
      chk(32'(wn), 32'h0);
      rchk(REG_ACCUM, 32'h5A);
      @(posedge i_clock);
      i_rst_n <= 1'b0;
      repeat (2) @(posedge i_clock);
      i_rst_n <= 1'b1;
      rchk(REG_ACCUM, 32'h0);
      rchk(REG_BANK, 32'h0);
      rchk(REG_CONTROL, 32'h0);
      rchk(REG_INDEX_BASE, 32'h0);
      rchk(REG_FLAGS, 32'h0);
      finish_test();
   end
endmodule
`default_nettype wire
